//--- src/dufc_defs.svh
/*
  Constants for the dual serial flow-control and configuration block.
  Assumes inclusion by bare name; definitions only.
*/
// Function
// - RTS and CTS act only with flow control
// - Enhanced RTS low below 191 bytes
// - Standard RTS watermark is 63 bytes
// - RTS goes high at watermark
// - At most two bytes after CTS high
// - Unprogrammed store gives built-in defaults
// - Default flushes all FIFOs on port open
// - Serial string max 16, default 8 chars
// - Product string max 47 characters
// - Interface strings max 32 characters
// - Store programmable in-system over USB
// - Modem or GPIO mode set only once
// - Default: every general pin is input
// - Transceiver enable active high, may be low
`ifndef DUFC_DEFS_SVH
`define DUFC_DEFS_SVH
`define DUFC_ENH_WATERMARK 16'd191
`define DUFC_STD_WATERMARK 16'd63
`define DUFC_CTS_GRACE_BYTES 2'd2
`define DUFC_SERIAL_MAX 5'd16
`define DUFC_SERIAL_DEFAULT 5'd8
`define DUFC_PRODUCT_MAX 6'd47
`define DUFC_IFNAME_MAX 6'd32
// Configuration word field positions
`define DUFC_CFG_ENH_MODEM 0
`define DUFC_CFG_STD_MODEM 1
`define DUFC_CFG_FLUSH_ON_OPEN 2
`define DUFC_CFG_XCVR_LOW 3
`define DUFC_CFG_SUSP_OD 4
`define DUFC_CFG_SUSP_HIGH 5
`define DUFC_CFG_ENH_HWFC 6
`define DUFC_CFG_STD_HWFC 7
`define DUFC_CFG_WIDTH 8
// Built-in defaults: GPIO mode, flush on open, active-high enable, push-pull low
`define DUFC_CFG_DEFAULT 8'h04
`endif

//--- src/dufc_pkg.sv
/*
  Types for the dual serial flow-control and configuration block.
  Assumes nothing of its surroundings.
*/
package dufc_pkg;
  typedef enum logic [1:0] {
    DUFC_TX_RUN,
    DUFC_TX_GRACE,
    DUFC_TX_HOLD
  } dufc_tx_state_type;
endpackage : dufc_pkg

//--- src/dufc_top.sv
/*
  Flow control for two serial interfaces plus a one-time programmable
  configuration store with in-system programming and string length limits.
  Assumes one 40 MHz clock, synchronous inputs, and a byte engine that
  pulses tx_byte_done per byte sent and honours tx_permit.
*/
`timescale 1ns/1ps
`include "dufc_defs.svh"

module dufc_top
  import dufc_pkg::*;
#(
  parameter int ENH_FIFO_DEPTH = 512,
  parameter int STD_FIFO_DEPTH = 256,
  parameter logic [15:0] ENH_WATERMARK = `DUFC_ENH_WATERMARK,
  parameter logic [15:0] STD_WATERMARK = `DUFC_STD_WATERMARK
) (
  input wire logic clock,
  input wire logic reset_n,
  // Receive FIFO fill levels: [0] enhanced, [1] standard
  input wire logic [15:0] enh_rx_level,
  input wire logic [15:0] std_rx_level,
  input wire logic [1:0] cts_n,
  input wire logic [1:0] tx_byte_done,
  input wire logic [1:0] port_open,
  // In-system programming over USB
  input wire logic prog_write,
  input wire logic [`DUFC_CFG_WIDTH-1:0] prog_data,
  input wire logic [4:0] prog_serial_len,
  input wire logic [5:0] prog_product_len,
  input wire logic [5:0] prog_enh_name_len,
  input wire logic [5:0] prog_std_name_len,
  input wire logic [1:0] suspended,
  input wire logic enh_transmitting,
  output logic [1:0] rts_n,
  output logic [1:0] tx_permit,
  output logic [1:0] fifo_flush,
  output logic [1:0] modem_mode,
  output logic [4:0] gpio_oe,
  output logic [1:0] suspend_indicator,
  output logic [1:0] suspend_indicator_oe,
  output logic enhanced_transceiver_enable,
  output logic store_programmed,
  output logic prog_rejected,
  output logic [`DUFC_CFG_WIDTH-1:0] active_config,
  output logic [4:0] serial_len,
  output logic [5:0] product_len,
  output logic [5:0] enh_name_len,
  output logic [5:0] std_name_len
);

  initial begin
    if (ENH_WATERMARK == 16'd0 || int'(ENH_WATERMARK) > ENH_FIFO_DEPTH)
      $error("Enhanced watermark outside FIFO depth");
    if (STD_WATERMARK == 16'd0 || int'(STD_WATERMARK) > STD_FIFO_DEPTH)
      $error("Standard watermark outside FIFO depth");
  end

  function automatic logic len_ok(input logic [5:0] len, input logic [5:0] max);
    len_ok = (len <= max);
  endfunction : len_ok

  logic programmed_ff;
  logic [`DUFC_CFG_WIDTH-1:0] cfg_ff;
  logic [1:0] open_d_ff;
  dufc_tx_state_type tx_state_ff [2];
  logic [1:0] grace_ff [2];
  logic [15:0] level [2];
  logic [15:0] mark [2];
  logic [1:0] hwfc;
  logic prog_ok;

  assign level[0] = enh_rx_level;
  assign level[1] = std_rx_level;
  assign mark[0] = ENH_WATERMARK;
  assign mark[1] = STD_WATERMARK;
  assign hwfc = {cfg_ff[`DUFC_CFG_STD_HWFC], cfg_ff[`DUFC_CFG_ENH_HWFC]};

  // One write only; oversize strings refuse the whole image
  assign prog_ok = !programmed_ff
    && len_ok({1'b0, prog_serial_len}, {1'b0, `DUFC_SERIAL_MAX})
    && prog_serial_len != 5'd0
    && len_ok(prog_product_len, `DUFC_PRODUCT_MAX)
    && len_ok(prog_enh_name_len, `DUFC_IFNAME_MAX)
    && len_ok(prog_std_name_len, `DUFC_IFNAME_MAX);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      programmed_ff <= 1'b0;
      cfg_ff <= `DUFC_CFG_DEFAULT;
      serial_len <= `DUFC_SERIAL_DEFAULT;
      product_len <= `DUFC_PRODUCT_MAX;
      enh_name_len <= `DUFC_IFNAME_MAX;
      std_name_len <= `DUFC_IFNAME_MAX;
      prog_rejected <= 1'b0;
    end else begin
      prog_rejected <= prog_write && !prog_ok;
      if (prog_write && prog_ok) begin
        programmed_ff <= 1'b1;
        cfg_ff <= prog_data;
        serial_len <= prog_serial_len;
        product_len <= prog_product_len;
        enh_name_len <= prog_enh_name_len;
        std_name_len <= prog_std_name_len;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      store_programmed <= 1'b0;
      active_config <= `DUFC_CFG_DEFAULT;
      modem_mode <= 2'b00;
    end else begin
      store_programmed <= programmed_ff;
      active_config <= cfg_ff;
      modem_mode <= {cfg_ff[`DUFC_CFG_STD_MODEM], cfg_ff[`DUFC_CFG_ENH_MODEM]};
    end
  end

  // Port open edge flushes both interfaces
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      open_d_ff <= 2'b00;
      fifo_flush <= 2'b00;
    end else begin
      open_d_ff <= port_open;
      if (cfg_ff[`DUFC_CFG_FLUSH_ON_OPEN] && |(port_open & ~open_d_ff))
        fifo_flush <= 2'b11;
      else
        fifo_flush <= 2'b00;
    end
  end

  // GPIO pins: enhanced two then standard three, inputs in every mode including modem mode
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gpio_oe <= 5'b00000;
    end else begin
      gpio_oe <= 5'b00000;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      suspend_indicator <= 2'b11;
      suspend_indicator_oe <= 2'b11;
      enhanced_transceiver_enable <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        // Active level per polarity bit; open drain only drives low
        suspend_indicator[i] <= cfg_ff[`DUFC_CFG_SUSP_HIGH] ? suspended[i]
                                                            : !suspended[i];
        suspend_indicator_oe[i] <= cfg_ff[`DUFC_CFG_SUSP_OD]
          ? (suspended[i] != cfg_ff[`DUFC_CFG_SUSP_HIGH]) : 1'b1;
      end
      enhanced_transceiver_enable <= enh_transmitting
                                     ^ cfg_ff[`DUFC_CFG_XCVR_LOW];
    end
  end

  // Flow control per interface
  for (genvar g = 0; g < 2; g++) begin : g_flow
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        rts_n[g] <= 1'b0;
      end else if (!hwfc[g]) begin
        rts_n[g] <= 1'b0;
      end else begin
        rts_n[g] <= (level[g] >= mark[g]);
      end
    end

    // Grace counts bytes finished after CTS rose; the byte engine stops
    // starting new bytes once permit drops, relying on the far side pacing
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        tx_state_ff[g] <= DUFC_TX_RUN;
        grace_ff[g] <= 2'd0;
        tx_permit[g] <= 1'b1;
      end else begin
        case (tx_state_ff[g])
          DUFC_TX_RUN: begin
            tx_permit[g] <= 1'b1;
            grace_ff[g] <= 2'd0;
            if (hwfc[g] && cts_n[g]) begin
              tx_state_ff[g] <= DUFC_TX_GRACE;
              grace_ff[g] <= tx_byte_done[g] ? 2'd1 : 2'd0;
            end
          end
          DUFC_TX_GRACE: begin
            if (!hwfc[g] || !cts_n[g]) begin
              tx_state_ff[g] <= DUFC_TX_RUN;
            end else if (tx_byte_done[g]) begin
              grace_ff[g] <= grace_ff[g] + 2'd1;
              // Permit drops once the second grace byte has finished
              if (grace_ff[g] + 2'd1 >= `DUFC_CTS_GRACE_BYTES) begin
                tx_permit[g] <= 1'b0;
                tx_state_ff[g] <= DUFC_TX_HOLD;
              end
            end
          end
          DUFC_TX_HOLD: begin
            tx_permit[g] <= 1'b0;
            if (!hwfc[g] || !cts_n[g]) begin
              tx_state_ff[g] <= DUFC_TX_RUN;
              tx_permit[g] <= 1'b1;
            end
          end
          default: tx_state_ff[g] <= DUFC_TX_RUN;
        endcase
      end
    end
  end

endmodule : dufc_top

//--- verif/dufc_checker.sv
/* Port assertions for the dual serial flow-control block.
   Assumes it is bound into dufc_top. */
`timescale 1ns/1ps
module dufc_checker #(
  parameter logic [15:0] ENH_WATERMARK = 16'h00bf,
  parameter logic [15:0] STD_WATERMARK = 16'h003f
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [15:0] enh_rx_level,
  input wire logic [15:0] std_rx_level,
  input wire logic [1:0] cts_n,
  input wire logic [1:0] tx_byte_done,
  input wire logic [1:0] port_open,
  input wire logic prog_write,
  input wire logic [1:0] suspended,
  input wire logic enh_transmitting,
  input wire logic [1:0] rts_n,
  input wire logic [1:0] tx_permit,
  input wire logic [1:0] fifo_flush,
  input wire logic [4:0] gpio_oe,
  input wire logic [1:0] suspend_indicator,
  input wire logic [1:0] suspend_indicator_oe,
  input wire logic enhanced_transceiver_enable,
  input wire logic store_programmed,
  input wire logic prog_rejected,
  input wire logic [7:0] active_config
);
  // Bytes sent since clear-to-send went high, saturating
  logic [1:0] grace_ff;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) grace_ff <= 2'h0;
    else if (!cts_n[0]) grace_ff <= 2'h0;
    else if (tx_byte_done[0] && grace_ff != 2'h3) grace_ff <= grace_ff + 2'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_rts_enh_level: assert property (
    rts_n[0] == (active_config[6] && $past(enh_rx_level) >= ENH_WATERMARK)) else $error("enh rts");
  a_rts_std_level: assert property (
    rts_n[1] == (active_config[7] && $past(std_rx_level) >= STD_WATERMARK)) else $error("std rts");
  a_cts_grace: assert property (
    tx_permit[0] == !(active_config[6] && grace_ff >= 2'h2)) else $error("tx permit");
  a_flush_on_open: assert property (
    $rose(port_open[0]) && active_config[2] |-> ##[1:2] fifo_flush == 2'h3) else $error("no flush");
  a_gpio_inputs: assert property (gpio_oe == 5'h00) else $error("gpio driven");
  a_xcvr_polarity: assert property (
    enhanced_transceiver_enable == ($past(enh_transmitting) ^ active_config[3])) else $error("xcvr");
  a_second_write: assert property (
    prog_write && store_programmed |-> ##[1:2] prog_rejected) else $error("rewrite taken");
  a_suspend_default: assert property (
    active_config[5:4] == 2'h0 |-> suspend_indicator_oe == 2'h3 &&
    suspend_indicator == ~$past(suspended)) else $error("suspend pin");
endmodule : dufc_checker

bind dufc_top dufc_checker #(.ENH_WATERMARK(ENH_WATERMARK), .STD_WATERMARK(STD_WATERMARK)) chk (.*);

//--- verif/dufc_far_uart.sv
/* Far-side serial device filling the enhanced receive FIFO.
   Assumes its controls change at the falling edge. */
`timescale 1ns/1ps
module dufc_far_uart (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic rts_n,
  input wire logic send,
  input wire logic drain,
  input wire logic nearly_full,
  output logic cts_n,
  output logic [15:0] level_out
);
  logic [15:0] level_ff;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) level_ff <= 16'h0000;
    else if (drain) level_ff <= 16'h0000;
    else if (send && !rts_n) level_ff <= level_ff + 16'h0001;
  end
  assign level_out = level_ff;
  assign cts_n = nearly_full;
endmodule : dufc_far_uart

//--- verif/tb.sv
/* Self-checking bench for dufc_top with a far-side model.
   Assumes the design, package and defs header are compiled first. */
`timescale 1ns/1ps
`include "dufc_defs.svh"
module tb;
  logic clock = 1'b0, reset_n = 1'b0, prog_write = 1'b0, enh_transmitting = 1'b0;
  logic send = 1'b0, drain = 1'b0, full = 1'b0, far_cts;
  logic [15:0] enh_rx_level, std_rx_level = 16'h0000;
  logic [1:0] cts_n, tx_byte_done = 2'h0, port_open = 2'h0, suspended = 2'h0, exp_rts = 2'h0;
  logic [1:0] rts_n, tx_permit, fifo_flush, modem_mode, suspend_indicator, suspend_indicator_oe;
  logic [4:0] gpio_oe, serial_len, prog_serial_len = 5'h00, s;
  logic [5:0] product_len, enh_name_len, std_name_len, prog_product_len = 6'h00;
  logic [5:0] prog_enh_name_len = 6'h00, prog_std_name_len = 6'h00;
  logic [7:0] prog_data = 8'h00, active_config, cfg_m = `DUFC_CFG_DEFAULT;
  logic enhanced_transceiver_enable, store_programmed, prog_rejected;
  int miscompares = 0, n_compared = 0;
  assign cts_n = {full, far_cts};
  dufc_top uut (.*);
  dufc_far_uart far (.clock, .reset_n, .rts_n(rts_n[0]), .send, .drain, .nearly_full(full),
    .cts_n(far_cts), .level_out(enh_rx_level));
  initial forever #12.5 clock = ~clock;
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  // Model of the watermark comparison, one cycle behind the levels
  always @(posedge clock) exp_rts <= {cfg_m[7] && std_rx_level >= `DUFC_STD_WATERMARK,
    cfg_m[6] && enh_rx_level >= `DUFC_ENH_WATERMARK};
  always @(negedge clock) begin
    if (reset_n) begin
      chk(rts_n, exp_rts);
      {enh_transmitting, suspended} = 3'($urandom);
      std_rx_level = 16'($urandom_range(0, 127));
    end
  end
  task automatic prog(input logic [7:0] d, input logic [4:0] sl, input logic [5:0] p, n,
    input logic rej);
    logic r;
    {prog_data, prog_serial_len, prog_product_len, prog_enh_name_len} = {d, sl, p, n};
    prog_std_name_len = n;
    prog_write = 1'b1;
    @(negedge clock);
    prog_write = 1'b0;
    if (!rej) cfg_m = d;
    r = prog_rejected;
    @(negedge clock);
    chk(r | prog_rejected, rej);
    @(negedge clock);
  endtask : prog
  task automatic open_chk;
    logic [1:0] acc;
    acc = 2'h0;
    port_open = 2'h0;
    @(negedge clock);
    port_open = 2'h3;
    repeat (3) begin
      @(negedge clock);
      acc = acc | fifo_flush;
    end
    chk(acc, 2'h3);
  endtask : open_chk
  initial begin
    void'($urandom(76));
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    chk({active_config, store_programmed, modem_mode, gpio_oe}, 16'h0400);
    chk({serial_len, product_len, enh_name_len}, {5'h08, 6'h2f, 6'h20});
    chk({std_name_len, suspend_indicator_oe}, {6'h20, 2'h3});
    open_chk();
    send = 1'b1;
    repeat (200) @(negedge clock);
    send = 1'b0;
    drain = 1'b1;
    @(negedge clock);
    drain = 1'b0;
    prog(8'hc7, 5'h00, 6'h10, 6'h10, 1'b1);
    prog(8'hc7, 5'h11, 6'h10, 6'h10, 1'b1);
    prog(8'hc7, 5'h10, 6'h30, 6'h10, 1'b1);
    prog(8'hc7, 5'h10, 6'h10, 6'h21, 1'b1);
    s = 5'($urandom_range(1, 16));
    prog(8'hc7, s, 6'h2f, 6'h20, 1'b0);
    chk({active_config, store_programmed, modem_mode, gpio_oe}, 16'hc7e0);
    chk({serial_len, product_len}, {s, 6'h2f});
    prog(8'h04, 5'h08, 6'h2f, 6'h20, 1'b1);
    open_chk();
    send = 1'b1;
    repeat (200) @(negedge clock);
    chk(enh_rx_level, `DUFC_ENH_WATERMARK + 16'h0001);
    full = 1'b1;
    for (int i = 0; i < 3; i++) begin
      tx_byte_done = 2'h3;
      @(negedge clock);
      tx_byte_done = 2'h0;
      @(negedge clock);
      chk(tx_permit, {2{i == 0}});
    end
    full = 1'b0;
    @(negedge clock);
    chk(tx_permit, 2'h3);
    end_sim();
  end
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule : tb
